// ===== hfn_pkg.sv
// constants, types and helpers shared by the hex-float normalizer files
package hfn_pkg;
   localparam int                   WORD_W     = 64;
   localparam int                   CHR_W      = 7;
   localparam int                   FRAC_W     = 56;
   localparam int                   SHORT_W    = 24;
   localparam int                   DIGIT_W    = 4;
   localparam int                   INT_W      = FRAC_W + DIGIT_W;
   localparam int                   SIGN_POS   = 63;
   localparam int                   CHR_MSB    = 62;
   localparam int                   CHR_LSB    = 56;
   localparam int                   FRAC_MSB   = 55;
   localparam int                   SHORT_LSB  = 32;
   localparam logic [CHR_W-1:0]     CHR_BIAS   = 7'h40;
   localparam logic [CHR_W-1:0]     CHR_MAX    = 7'h7f;
   localparam logic [CHR_W-1:0]     CHR_ZERO   = 7'h00;
   localparam logic [INT_W-1:0]     INT_ZERO   = 60'h0;
   localparam logic [WORD_W-1:0]    WORD_ZERO  = 64'h0;

   typedef enum logic [1:0]
   {
      OP_ADD = 2'h0,
      OP_SUB = 2'h1,
      OP_MUL = 2'h2,
      OP_DIV = 2'h3
   } hfn_op_t;

   typedef logic [INT_W-1:0] hfn_int_t;

   // normalized exactly when the top hex digit is non-zero
   function automatic logic hfn_is_norm(input hfn_int_t f);
      return f[INT_W-1 -: DIGIT_W] != 4'h0;
   endfunction

   // fraction of an operand widened to the working format, guard digit last
   function automatic hfn_int_t hfn_unpack(input logic [WORD_W-1:0] w, input logic lng);
      hfn_int_t f;
      f = {w[FRAC_MSB:0], 4'h0};
      if (!lng)
         f = {w[FRAC_MSB:SHORT_LSB], 36'h0};
      return f;
   endfunction
endpackage

// ===== hfn_norm_if.sv
// handshake between the sequencer and the digit normalizer
`timescale 1ns/10ps
interface hfn_norm_if;
   import hfn_pkg::*;
   logic                start;
   hfn_int_t            frac_in;
   logic [CHR_W-1:0]    chr_in;
   logic                busy;
   logic                done;
   hfn_int_t            frac_out;
   logic [CHR_W-1:0]    chr_out;
   logic                underflow;

   modport ctl (output start, frac_in, chr_in, input busy, done, frac_out, chr_out, underflow);
   modport nrm (input start, frac_in, chr_in, output busy, done, frac_out, chr_out, underflow);
endinterface

// ===== hfn_norm.sv
// one-digit-per-cycle fraction normalizer
`timescale 1ns/10ps
module hfn_norm
(
   input  wire logic    mclk,
   input  wire logic    reset,
   hfn_norm_if.nrm      nif
);
   import hfn_pkg::*;

   typedef struct packed
   {
      logic                busy;
      logic                done;
      logic                unf;
      hfn_int_t            frac;
      logic [CHR_W-1:0]    chr;
   } hfn_norm_st_t;

   hfn_norm_st_t s_reg;
   hfn_norm_st_t s_next;

   always_comb
   begin
      s_next = s_reg;
      s_next.done = 1'b0;
      if (!s_reg.busy && nif.start)
      begin
         s_next.busy = 1'b1;
         s_next.unf  = 1'b0;
         s_next.frac = nif.frac_in;
         s_next.chr  = nif.chr_in;
      end
      else if (s_reg.busy)
      begin
         // zero fraction: no shift, characteristic kept
         if (s_reg.frac == INT_ZERO || hfn_is_norm(s_reg.frac))
         begin
            s_next.busy = 1'b0;
            s_next.done = 1'b1;
         end
         else
         begin
            s_next.frac = {s_reg.frac[INT_W-DIGIT_W-1:0], 4'h0};
            s_next.chr  = s_reg.chr - 7'h01;
            if (s_reg.chr == CHR_ZERO)
               s_next.unf = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   assign nif.busy      = s_reg.busy;
   assign nif.done      = s_reg.done;
   assign nif.frac_out  = s_reg.frac;
   assign nif.chr_out   = s_reg.chr;
   assign nif.underflow = s_reg.unf;
endmodule

// ===== hfn_unit.sv
// hex floating-point align, add/subtract and normalize datapath
`timescale 1ns/10ps
module hfn_unit
(
   input  wire logic                        mclk,
   input  wire logic                        reset,
   input  wire logic                        start,
   input  wire hfn_pkg::hfn_op_t            op,
   input  wire logic                        long_form,
   input  wire logic                        norm_mode,
   input  wire logic [hfn_pkg::WORD_W-1:0]  opnd_a,
   input  wire logic [hfn_pkg::WORD_W-1:0]  opnd_b,
   output logic                             busy,
   output logic                             done,
   output logic [hfn_pkg::WORD_W-1:0]       result,
   output logic [hfn_pkg::WORD_W-1:0]       result_b,
   output logic                             exp_overflow,
   output logic                             exp_underflow
);
   import hfn_pkg::*;

   typedef enum logic [6:0]
   {
      ST_IDLE  = 7'b0000001,
      ST_ALIGN = 7'b0000010,
      ST_ARITH = 7'b0000100,
      ST_POST  = 7'b0001000,
      ST_PRE_A = 7'b0010000,
      ST_PRE_B = 7'b0100000,
      ST_PACK  = 7'b1000000
   } hfn_state_t;

   typedef struct packed
   {
      hfn_state_t          st;
      logic                lng;
      logic                nrm;
      logic                mul_div;
      logic                wait_n;
      logic                sa;
      logic                sb;
      logic [CHR_W-1:0]    ca;
      logic [CHR_W-1:0]    cb;
      hfn_int_t            fa;
      hfn_int_t            fb;
      logic                done;
      logic                ovf;
      logic                unf;
      logic [WORD_W-1:0]   res;
      logic [WORD_W-1:0]   res_b;
   } hfn_unit_st_t;

   hfn_unit_st_t s_reg;
   hfn_unit_st_t s_next;
   hfn_norm_if   nif ();

   // truncate to final length, force zero characteristic on a zero fraction, place fields
   function automatic logic [WORD_W-1:0] pack_word(input logic s, input logic [CHR_W-1:0] c,
                                                   input hfn_int_t f, input logic lng);
      logic [WORD_W-1:0] w;
      logic [CHR_W-1:0]  cc;
      logic [FRAC_W-1:0] ff;
      ff = f[INT_W-1:DIGIT_W];
      if (!lng)
         ff = {ff[FRAC_W-1:FRAC_W-SHORT_W], 32'h0};
      cc = (ff == '0) ? CHR_ZERO : c;
      w  = WORD_ZERO;
      w[SIGN_POS] = s;
      w[CHR_MSB:CHR_LSB] = cc;
      w[FRAC_MSB:0] = ff;
      if (!lng)
         w[SHORT_LSB-1:0] = 32'h0;
      return w;
   endfunction

   hfn_norm u_norm
   (
      .mclk  (mclk),
      .reset (reset),
      .nif   (nif)
   );

   logic [INT_W:0]  sum_w;
   logic            a_ge_b;

   always_comb
   begin
      sum_w  = {1'b0, s_reg.fa} + {1'b0, s_reg.fb};
      a_ge_b = s_reg.fa >= s_reg.fb;
   end

   always_comb
   begin
      s_next = s_reg;
      s_next.done = 1'b0;
      nif.start   = 1'b0;
      nif.frac_in = s_reg.fa;
      nif.chr_in  = s_reg.ca;
      unique case (s_reg.st)
         ST_IDLE:
         begin
            if (start)
            begin
               // operands taken as they come, normalized or not
               s_next.lng     = long_form;
               s_next.nrm     = norm_mode;
               s_next.mul_div = (op == OP_MUL) || (op == OP_DIV);
               s_next.wait_n  = 1'b0;
               s_next.ovf     = 1'b0;
               s_next.unf     = 1'b0;
               s_next.sa      = opnd_a[SIGN_POS];
               s_next.sb      = opnd_b[SIGN_POS] ^ (op == OP_SUB);
               s_next.ca      = opnd_a[CHR_MSB:CHR_LSB];
               s_next.cb      = opnd_b[CHR_MSB:CHR_LSB];
               s_next.fa      = hfn_unpack(opnd_a, long_form);
               s_next.fb      = hfn_unpack(opnd_b, long_form);
               s_next.st      = s_next.mul_div ? ST_PRE_A : ST_ALIGN;
            end
         end
         ST_ALIGN:
         begin
            // one digit per cycle; bits past the guard digit are lost
            if (s_reg.ca == s_reg.cb)
               s_next.st = ST_ARITH;
            else if (s_reg.ca < s_reg.cb)
            begin
               s_next.fa = {4'h0, s_reg.fa[INT_W-1:DIGIT_W]};
               s_next.ca = s_reg.ca + 7'h01;
               if (s_next.fa == INT_ZERO)
                  s_next.ca = s_reg.cb;
            end
            else
            begin
               s_next.fb = {4'h0, s_reg.fb[INT_W-1:DIGIT_W]};
               s_next.cb = s_reg.cb + 7'h01;
               if (s_next.fb == INT_ZERO)
                  s_next.cb = s_reg.ca;
            end
         end
         ST_ARITH:
         begin
            if (s_reg.sa == s_reg.sb)
            begin
               if (sum_w[INT_W])
               begin
                  // carry out: shift right one digit, characteristic up
                  s_next.fa = sum_w[INT_W:DIGIT_W+1] == '0 ? INT_ZERO :
                              {3'h0, sum_w[INT_W:DIGIT_W]};
                  s_next.ca = s_reg.ca + 7'h01;
                  if (s_reg.ca == CHR_MAX)
                     s_next.ovf = 1'b1;
               end
               else
                  s_next.fa = sum_w[INT_W-1:0];
            end
            else if (a_ge_b)
               s_next.fa = s_reg.fa - s_reg.fb;
            else
            begin
               s_next.fa = s_reg.fb - s_reg.fa;
               s_next.sa = s_reg.sb;
            end
            if (s_next.fa == INT_ZERO)
               s_next.sa = 1'b0;
            // unnormalized mode leaves leading zero digits in place
            s_next.st = s_reg.nrm ? ST_POST : ST_PACK;
         end
         ST_POST:
         begin
            nif.start = !s_reg.wait_n;
            s_next.wait_n = 1'b1;
            if (nif.done)
            begin
               s_next.fa     = nif.frac_out;
               s_next.ca     = nif.chr_out;
               s_next.unf    = nif.underflow;
               s_next.wait_n = 1'b0;
               s_next.st     = ST_PACK;
            end
         end
         ST_PRE_A:
         begin
            nif.start = !s_reg.wait_n;
            s_next.wait_n = 1'b1;
            if (nif.done)
            begin
               s_next.fa     = nif.frac_out;
               s_next.ca     = nif.chr_out;
               s_next.unf    = nif.underflow;
               s_next.wait_n = 1'b0;
               s_next.st     = ST_PRE_B;
            end
         end
         ST_PRE_B:
         begin
            nif.start   = !s_reg.wait_n;
            nif.frac_in = s_reg.fb;
            nif.chr_in  = s_reg.cb;
            s_next.wait_n = 1'b1;
            if (nif.done)
            begin
               s_next.fb     = nif.frac_out;
               s_next.cb     = nif.chr_out;
               s_next.unf    = s_reg.unf | nif.underflow;
               s_next.wait_n = 1'b0;
               s_next.st     = ST_PACK;
            end
         end
         ST_PACK:
         begin
            s_next.res   = pack_word(s_reg.sa, s_reg.ca, s_reg.fa, s_reg.lng);
            // for add/subtract the second word is undefined, so it is cleared
            s_next.res_b = s_reg.mul_div ?
                           pack_word(opnd_b_sign(s_reg), s_reg.cb, s_reg.fb, s_reg.lng) :
                           WORD_ZERO;
            s_next.done  = 1'b1;
            s_next.st    = ST_IDLE;
         end
      endcase
   end

   // multiply/divide keep operand b sign untouched by the subtract flip
   function automatic logic opnd_b_sign(input hfn_unit_st_t s);
      return s.sb;
   endfunction

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         s_reg    <= '0;
         s_reg.st <= ST_IDLE;
      end
      else
         s_reg <= s_next;
   end

   assign busy          = s_reg.st != ST_IDLE;
   assign done          = s_reg.done;
   assign result        = s_reg.res;
   assign result_b      = s_reg.res_b;
   assign exp_overflow  = s_reg.ovf;
   assign exp_underflow = s_reg.unf;
endmodule

// ===== hfn_unit_properties.sv
// concurrent properties of the hex-float normalizer datapath
`timescale 1ns/10ps
module hfn_unit_properties
(
   input wire logic                        mclk,
   input wire logic                        reset,
   input wire logic                        start,
   input wire hfn_pkg::hfn_op_t            op,
   input wire logic                        long_form,
   input wire logic                        norm_mode,
   input wire logic                        busy,
   input wire logic                        done,
   input wire logic [hfn_pkg::WORD_W-1:0]  result,
   input wire logic [hfn_pkg::WORD_W-1:0]  result_b,
   input wire logic                        exp_overflow,
   input wire logic                        exp_underflow
);
   import hfn_pkg::*;
   logic    md_reg;
   logic    an_reg;
   logic    lg_reg;

   // remembers what the request in flight asked for
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         md_reg <= 1'b0;
         an_reg <= 1'b0;
         lg_reg <= 1'b0;
      end
      else if (start && !busy)
      begin
         md_reg <= op[1];
         an_reg <= !op[1] && norm_mode;
         lg_reg <= long_form;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   a_take_busy: assert property (start && !busy |=> busy)
      else $error("request not taken");
   a_done_bound: assert property (start && !busy |-> ##[3:200] done)
      else $error("no completion");
   a_zero_char: assert property (done && result[55:0] == 56'h0 |-> result[62:56] == CHR_ZERO)
      else $error("zero fraction with nonzero characteristic");
   a_zero_char_b: assert property (done && result_b[55:0] == 56'h0 |-> result_b[62:56] == 7'h00)
      else $error("zero fraction b with nonzero characteristic");
   a_prenorm_a: assert property (done && md_reg |-> result[55:52] != 4'h0 || result[55:0] == 56'h0)
      else $error("operand a not normalized");
   a_prenorm_b: assert property (done && md_reg |-> result_b[55:52] != 4'h0 || result_b[55:0] == 56'h0)
      else $error("operand b not normalized");
   a_post_norm: assert property (done && an_reg |-> result[55:52] != 4'h0 || result[55:0] == 56'h0)
      else $error("sum not post-normalized");
   a_b_unused: assert property (done && !md_reg |-> result_b == WORD_ZERO)
      else $error("second result not clear");
   a_short_trunc: assert property (done && !lg_reg |-> result[31:0] == 32'h0 && result_b[31:0] == 32'h0)
      else $error("short result not truncated");

   c_norm_add: cover property (done && an_reg);
   c_prenorm: cover property (done && md_reg);
   c_overflow: cover property (done && exp_overflow);
   c_underflow: cover property (done && exp_underflow);
endmodule

bind hfn_unit hfn_unit_properties i_hfn_unit_properties (.mclk(mclk), .reset(reset), .start(start),
   .op(op), .long_form(long_form), .norm_mode(norm_mode), .busy(busy), .done(done),
   .result(result), .result_b(result_b), .exp_overflow(exp_overflow), .exp_underflow(exp_underflow));

// ===== tb_hfn_unit.sv
// self-checking bench for the hex-float normalizer datapath
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_hfn_unit;
   import hfn_pkg::*;
   logic          mclk = 1'b0;
   logic          reset;
   logic          start;
   hfn_op_t       op;
   logic          long_form;
   logic          norm_mode;
   logic [63:0]   opnd_a;
   logic [63:0]   opnd_b;
   logic          busy;
   logic          done;
   logic [63:0]   result;
   logic [63:0]   result_b;
   logic          exp_overflow;
   logic          exp_underflow;
   int            miscompares;
   int            cmp_count;
   int            lat;

   hfn_unit i_hfn_unit (.mclk(mclk), .reset(reset), .start(start), .op(op),
      .long_form(long_form), .norm_mode(norm_mode), .opnd_a(opnd_a), .opnd_b(opnd_b),
      .busy(busy), .done(done), .result(result), .result_b(result_b),
      .exp_overflow(exp_overflow), .exp_underflow(exp_underflow));

   always #20 mclk = ~mclk;

   function automatic logic [63:0] w(input int s, input logic [6:0] c, input logic [55:0] f);
      return {s[0], c, f};
   endfunction

   // one request; lat counts edges from take to done
   task automatic go(input hfn_op_t o, input logic lg, input logic nm,
                     input logic [63:0] a, input logic [63:0] b);
      @(negedge mclk);
      start = 1'b1;
      op = o;
      long_form = lg;
      norm_mode = nm;
      opnd_a = a;
      opnd_b = b;
      @(negedge mclk);
      start = 1'b0;
      lat = 1;
      @(posedge mclk);
      #1;
      while (done !== 1'b1 && lat < 300)
      begin
         lat++;
         @(posedge mclk);
         #1;
      end
   endtask

   task automatic s_add_plain();
      go(OP_ADD, 1'b1, 1'b0, w(0, 7'h41, 56'h10000000000000), w(0, 7'h41, 56'h01000000000000));
      `CHK(result, w(0, 7'h41, 56'h11000000000000))
      `CHK(lat, 3)
      `CHK(result_b, 64'h0)
      `CHK(busy, 1'b0)
   endtask

   task automatic s_align();
      go(OP_ADD, 1'b1, 1'b0, w(0, 7'h42, 56'h10000000000000), w(0, 7'h41, 56'h10000000000000));
      `CHK(result, w(0, 7'h42, 56'h11000000000000))
      `CHK(lat, 4)
      go(OP_ADD, 1'b1, 1'b0, w(0, 7'h41, 56'h10000000000000), w(0, 7'h42, 56'h10000000000000));
      `CHK(result, w(0, 7'h42, 56'h11000000000000))
   endtask

   task automatic s_carry();
      go(OP_ADD, 1'b1, 1'b0, w(0, 7'h41, 56'hf0000000000000), w(0, 7'h41, 56'h10000000000000));
      `CHK(result, w(0, 7'h42, 56'h10000000000000))
      `CHK(exp_overflow, 1'b0)
      // top characteristic wraps on carry
      go(OP_ADD, 1'b1, 1'b0, w(0, 7'h7f, 56'hf0000000000000), w(0, 7'h7f, 56'h10000000000000));
      `CHK(result, w(0, 7'h00, 56'h10000000000000))
      `CHK(exp_overflow, 1'b1)
   endtask

   task automatic s_sign();
      go(OP_SUB, 1'b1, 1'b0, w(0, 7'h41, 56'h10000000000000), w(0, 7'h41, 56'h30000000000000));
      `CHK(result, w(1, 7'h41, 56'h20000000000000))
      go(OP_SUB, 1'b1, 1'b0, w(0, 7'h41, 56'h10000000000000), w(1, 7'h41, 56'h20000000000000));
      `CHK(result, w(0, 7'h41, 56'h30000000000000))
      go(OP_SUB, 1'b1, 1'b0, w(1, 7'h43, 56'h50000000000000), w(1, 7'h43, 56'h50000000000000));
      `CHK(result, 64'h0)
   endtask

   task automatic s_norm_mode();
      go(OP_ADD, 1'b1, 1'b1, w(0, 7'h41, 56'h00100000000000), w(0, 7'h41, 56'h00100000000000));
      `CHK(result, w(0, 7'h3f, 56'h20000000000000))
      go(OP_ADD, 1'b1, 1'b0, w(0, 7'h41, 56'h00100000000000), w(0, 7'h41, 56'h00100000000000));
      `CHK(result, w(0, 7'h41, 56'h00200000000000))
   endtask

   task automatic s_prenorm();
      go(OP_MUL, 1'b1, 1'b0, w(0, 7'h40, 56'h00030000000000), w(1, 7'h44, 56'h1abcdef0123456));
      `CHK(result, w(0, 7'h3d, 56'h30000000000000))
      `CHK(result_b, w(1, 7'h44, 56'h1abcdef0123456))
      go(OP_MUL, 1'b1, 1'b0, 64'h0, w(0, 7'h41, 56'h10000000000000));
      `CHK(result, 64'h0)
      // short form ignores and clears the low word
      go(OP_DIV, 1'b0, 1'b0, {1'b0, 7'h42, 24'h000100, 32'hffffffff}, {1'b0, 7'h01, 24'h000100, 32'h0});
      `CHK(result, {1'b0, 7'h3f, 24'h100000, 32'h0})
      `CHK(result_b, {1'b0, 7'h7e, 24'h100000, 32'h0})
      `CHK(exp_underflow, 1'b1)
   endtask

   task automatic report_and_stop();
      if (miscompares == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial
   begin
      #200000;
      miscompares++;
      report_and_stop();
   end

   initial
   begin
      reset = 1'b1;
      start = 1'b0;
      op = OP_ADD;
      long_form = 1'b1;
      norm_mode = 1'b0;
      opnd_a = 64'h0;
      opnd_b = 64'h0;
      repeat (16) @(negedge mclk);
      reset = 1'b0;
      s_add_plain();
      s_align();
      s_carry();
      s_sign();
      s_norm_mode();
      s_prenorm();
      report_and_stop();
   end
endmodule
